// ==== logic/usw_pkg.sv ====
// Constants, field layouts and carrier types for the unit status word encoder
package usw_pkg;

	localparam int UNITS = 8;
	localparam int BYTE_W = 8;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] SYS_BYTE_ONE = 8'h00;
	localparam logic [7:0] SYS_BYTE_TWO = 8'h01;
	localparam logic [7:0] SYS_DRIVER_LOSS = 8'h02;
	localparam logic [7:0] SYS_COOLER_LOSS = 8'h03;
	localparam logic [7:0] SYS_VERSION = 8'h04;
	localparam logic [7:0] CTRL = 8'h05;
	localparam logic [7:0] VERSION_SET = 8'h06;
	localparam logic [7:0] EVENT_CLEAR = 8'h07;
	localparam logic [7:0] DRIVER_PRESENT = 8'h08;
	localparam logic [7:0] COOLER_PRESENT = 8'h09;
	localparam logic [1:0] DRIVER_WINDOW = 2'h1;
	localparam logic [1:0] COOLER_WINDOW = 2'h2;

	// Byte slots inside one unit window
	localparam logic [2:0] UNIT_STATUS = 3'h0;
	localparam logic [2:0] UNIT_FAULT = 3'h1;
	localparam logic [2:0] UNIT_GROUP = 3'h2;
	localparam logic [2:0] UNIT_INTERNAL_A = 3'h3;
	localparam logic [2:0] UNIT_INTERNAL_B = 3'h4;
	localparam logic [2:0] UNIT_VERSION = 3'h5;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int SYS_FAIL_BIT = 2;
	localparam int SYS_LASER_BIT = 3;
	localparam int SYS_ILOCK_BIT = 4;
	localparam int SYS_REMOTE_BIT = 5;
	localparam int SYS_OVERTEMP_BIT = 6;
	localparam int SYS_FIRST_BIT = 7;
	localparam int CARD_NEW_BIT = 0;
	localparam int CARD_IN_BIT = 1;
	localparam int CARD_FAULT_BIT = 2;
	localparam int ANY_FAULT_BIT = 3;
	localparam int DRIVER_FAULT_BIT = 4;
	localparam int COOLER_FAULT_BIT = 5;
	localparam int MEAS_BIT = 6;
	localparam int STATION_BIT = 7;
	localparam int UNIT_FIRST_BIT = 3;
	localparam int UNIT_ILOCK_BIT = 4;
	localparam int UNIT_FAN_BIT = 4;
	localparam int UNIT_CONFIG_BIT = 5;
	localparam int UNIT_ACTIVE_BIT = 6;
	localparam int UNIT_LASER_BIT = 7;
	localparam int UNIT_FAIL_BIT = 0;
	localparam int RELAY_BIT = 1;
	localparam int AMP_BIT = 2;
	localparam int PELTIER_BIT = 1;
	localparam int PULSE_ILOCK_BIT = 3;
	localparam int FAN_DEFECT_BIT = 3;
	localparam int DRV_OVERTEMP_BIT = 4;
	localparam int LASER_OVERTEMP_BIT = 4;
	localparam int COOL_OVERTEMP_BIT = 5;
	localparam int TYPE_LSB = 4;
	localparam int CTRL_REMOTE_BIT = 0;

	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] VERSION_RESET = 8'h01;
	localparam logic [7:0] PRESENT_RESET = 8'hFF;
	localparam int CLK_HZ = 25000000;
	localparam int LOSS_TIME_MS = 2500;
	localparam int LOSS_CYCLES = LOSS_TIME_MS * (CLK_HZ / 1000);

	// ****************************************
	// Carriers
	// ****************************************
	typedef enum logic [1:0] {
		USW_TYPE_L = 2'b00,
		USW_TYPE_M = 2'b01,
		USW_TYPE_H = 2'b10,
		USW_TYPE_X = 2'b11
	} usw_type_e;

	typedef struct packed {
		logic [1:0] op_mode;
		logic failure;
		logic interlock_open;
		logic board_overtemp;
		logic card_inserted;
		logic card_fault;
		logic meas_connected;
		logic station_connected;
	} usw_system_s;

	typedef struct packed {
		logic [2:0] op_mode;
		logic first_msg;
		logic interlock_open;
		logic configured;
		logic active;
		logic laser_on;
		logic failure;
		logic relay_defect;
		logic amp_defect;
		logic pulse_interlock;
		logic overtemp;
		logic [3:0] group;
		usw_type_e unit_type;
		logic [7:0] internal_a;
		logic [7:0] internal_b;
		logic [7:0] version;
	} usw_driver_s;

	typedef struct packed {
		logic [2:0] op_mode;
		logic first_msg;
		logic fan_ctrl;
		logic configured;
		logic active;
		logic failure;
		logic peltier_defect;
		logic fan_defect;
		logic laser_overtemp;
		logic board_overtemp;
		logic [7:0] internal_a;
		logic [7:0] internal_b;
		logic [7:0] version;
	} usw_cooler_s;

	typedef struct packed {
		logic [7:0] byte_one;
		logic [7:0] byte_two;
		logic [7:0] driver_loss;
		logic [7:0] cooler_loss;
		logic [7:0] version;
	} usw_sys_msg_s;

endpackage

// ==== logic/usw_encoder.sv ====
// Unit status word encoder: system, driver and cooler status bytes
`timescale 1ns/1ps

module usw_encoder #(
	parameter int LOSS_CYCLES = usw_pkg::LOSS_CYCLES
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// System controller state
	input wire usw_pkg::usw_system_s sys_state,
	input wire logic card_changed,
	input wire logic sys_msg_sent,
	// Received unit status messages
	input wire logic [usw_pkg::UNITS-1:0] driver_valid,
	input wire usw_pkg::usw_driver_s driver_msg [usw_pkg::UNITS],
	input wire logic [usw_pkg::UNITS-1:0] cooler_valid,
	input wire usw_pkg::usw_cooler_s cooler_msg [usw_pkg::UNITS],
	// Outgoing system status message
	output usw_pkg::usw_sys_msg_s sys_msg
);

	// ****************************************
	// Storage
	// ****************************************
	logic [7:0] ctrl;
	logic [7:0] version_set;
	logic [7:0] driver_present;
	logic [7:0] cooler_present;
	logic first_pending;
	logic card_new;
	usw_pkg::usw_driver_s driver_snap [usw_pkg::UNITS];
	usw_pkg::usw_cooler_s cooler_snap [usw_pkg::UNITS];
	logic [usw_pkg::UNITS-1:0] driver_lost;
	logic [usw_pkg::UNITS-1:0] cooler_lost;
	logic [31:0] driver_age [usw_pkg::UNITS];
	logic [31:0] cooler_age [usw_pkg::UNITS];
	logic [7:0] next_byte_one;
	logic [7:0] next_byte_two;
	logic [7:0] next_rdata;
	logic any_laser;
	logic any_overtemp;
	logic any_driver_fault;
	logic any_cooler_fault;
	logic wr_clear;

	localparam logic [31:0] LOSS_LIMIT = 32'(LOSS_CYCLES);

	// ****************************************
	// Byte builders
	// ****************************************
	function automatic logic [7:0] driver_fault_byte(input usw_pkg::usw_driver_s s);
		logic [7:0] b;
		b = 8'h00;
		b[usw_pkg::UNIT_FAIL_BIT] = s.failure | s.relay_defect | s.amp_defect
			| s.pulse_interlock | s.overtemp;
		b[usw_pkg::RELAY_BIT] = s.relay_defect;
		b[usw_pkg::AMP_BIT] = s.amp_defect;
		b[usw_pkg::PULSE_ILOCK_BIT] = s.pulse_interlock;
		b[usw_pkg::DRV_OVERTEMP_BIT] = s.overtemp;
		return b;
	endfunction

	function automatic logic [7:0] cooler_fault_byte(input usw_pkg::usw_cooler_s s);
		logic [7:0] b;
		b = 8'h00;
		b[usw_pkg::UNIT_FAIL_BIT] = s.failure | s.peltier_defect | s.fan_defect
			| s.laser_overtemp | s.board_overtemp;
		b[usw_pkg::PELTIER_BIT] = s.peltier_defect;
		b[usw_pkg::FAN_DEFECT_BIT] = s.fan_defect;
		b[usw_pkg::LASER_OVERTEMP_BIT] = s.laser_overtemp;
		b[usw_pkg::COOL_OVERTEMP_BIT] = s.board_overtemp;
		return b;
	endfunction

	function automatic logic [7:0] driver_byte(input usw_pkg::usw_driver_s s,
			input logic [2:0] slot);
		logic [7:0] b;
		b = 8'h00;
		if (slot == usw_pkg::UNIT_STATUS) begin
			b[2:0] = s.op_mode;
			b[usw_pkg::UNIT_FIRST_BIT] = s.first_msg;
			b[usw_pkg::UNIT_ILOCK_BIT] = s.interlock_open;
			b[usw_pkg::UNIT_CONFIG_BIT] = s.configured;
			b[usw_pkg::UNIT_ACTIVE_BIT] = s.active;
			b[usw_pkg::UNIT_LASER_BIT] = s.laser_on;
		end else if (slot == usw_pkg::UNIT_FAULT) begin
			b = driver_fault_byte(s);
		end else if (slot == usw_pkg::UNIT_GROUP) begin
			b[3:0] = s.group;
			b[usw_pkg::TYPE_LSB + int'(s.unit_type)] = 1'b1;
		end else if (slot == usw_pkg::UNIT_INTERNAL_A) begin
			b = s.internal_a;
		end else if (slot == usw_pkg::UNIT_INTERNAL_B) begin
			b = s.internal_b;
		end else if (slot == usw_pkg::UNIT_VERSION) begin
			b = s.version;
		end
		return b;
	endfunction

	function automatic logic [7:0] cooler_byte(input usw_pkg::usw_cooler_s s,
			input logic [2:0] slot);
		logic [7:0] b;
		b = 8'h00;
		if (slot == usw_pkg::UNIT_STATUS) begin
			b[2:0] = s.op_mode;
			b[usw_pkg::UNIT_FIRST_BIT] = s.first_msg;
			b[usw_pkg::UNIT_FAN_BIT] = s.fan_ctrl;
			b[usw_pkg::UNIT_CONFIG_BIT] = s.configured;
			b[usw_pkg::UNIT_ACTIVE_BIT] = s.active;
		end else if (slot == usw_pkg::UNIT_FAULT) begin
			b = cooler_fault_byte(s);
		end else if (slot == usw_pkg::UNIT_INTERNAL_A) begin
			b = s.internal_a;
		end else if (slot == usw_pkg::UNIT_INTERNAL_B) begin
			b = s.internal_b;
		end else if (slot == usw_pkg::UNIT_VERSION) begin
			b = s.version;
		end
		return b;
	endfunction

	// ****************************************
	// Software registers
	// ****************************************
	assign wr_clear = reg_wr && (reg_addr == usw_pkg::EVENT_CLEAR) && reg_wdata[0];

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl <= usw_pkg::CTRL_RESET;
			version_set <= usw_pkg::VERSION_RESET;
			driver_present <= usw_pkg::PRESENT_RESET;
			cooler_present <= usw_pkg::PRESENT_RESET;
		end else if (ce && reg_wr) begin
			if (reg_addr == usw_pkg::CTRL) begin
				ctrl <= reg_wdata;
			end else if (reg_addr == usw_pkg::VERSION_SET) begin
				version_set <= reg_wdata;
			end else if (reg_addr == usw_pkg::DRIVER_PRESENT) begin
				driver_present <= reg_wdata;
			end else if (reg_addr == usw_pkg::COOLER_PRESENT) begin
				cooler_present <= reg_wdata;
			end
		end
	end

	// ****************************************
	// Event flags
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			first_pending <= 1'b1;
		end else if (ce && sys_msg_sent) begin
			first_pending <= 1'b0;
		end
	end

	// New card is sticky; a change in the clearing cycle still sets it
	always_ff @(posedge clk) begin
		if (rst) begin
			card_new <= 1'b0;
		end else if (ce) begin
			if (card_changed) begin
				card_new <= 1'b1;
			end else if (wr_clear) begin
				card_new <= 1'b0;
			end
		end
	end

	// ****************************************
	// Unit snapshots and loss watch
	// ****************************************
	for (genvar i = 0; i < usw_pkg::UNITS; i++) begin : g_unit
		always_ff @(posedge clk) begin
			if (rst) begin
				driver_snap[i] <= '0;
			end else if (ce && driver_valid[i]) begin
				driver_snap[i] <= driver_msg[i];
			end
		end

		always_ff @(posedge clk) begin
			if (rst) begin
				cooler_snap[i] <= '0;
			end else if (ce && cooler_valid[i]) begin
				cooler_snap[i] <= cooler_msg[i];
			end
		end

		// Age counts cycles since the unit's last message
		always_ff @(posedge clk) begin
			if (rst) begin
				driver_age[i] <= 32'h00000000;
				driver_lost[i] <= 1'b0;
			end else if (ce) begin
				if (driver_valid[i] || !driver_present[i]) begin
					driver_age[i] <= 32'h00000000;
					driver_lost[i] <= 1'b0;
				end else if (driver_age[i] < LOSS_LIMIT) begin
					driver_age[i] <= driver_age[i] + 32'h00000001;
				end else begin
					driver_lost[i] <= 1'b1;
				end
			end
		end

		always_ff @(posedge clk) begin
			if (rst) begin
				cooler_age[i] <= 32'h00000000;
				cooler_lost[i] <= 1'b0;
			end else if (ce) begin
				if (cooler_valid[i] || !cooler_present[i]) begin
					cooler_age[i] <= 32'h00000000;
					cooler_lost[i] <= 1'b0;
				end else if (cooler_age[i] < LOSS_LIMIT) begin
					cooler_age[i] <= cooler_age[i] + 32'h00000001;
				end else begin
					cooler_lost[i] <= 1'b1;
				end
			end
		end
	end

	// ****************************************
	// System summary
	// ****************************************
	always_comb begin
		any_laser = 1'b0;
		any_overtemp = sys_state.board_overtemp;
		any_driver_fault = |driver_lost;
		any_cooler_fault = |cooler_lost;
		for (int i = 0; i < usw_pkg::UNITS; i++) begin
			any_laser = any_laser | (driver_present[i] & driver_snap[i].laser_on);
			any_overtemp = any_overtemp | (driver_present[i] & driver_snap[i].overtemp)
				| (cooler_present[i] & cooler_snap[i].board_overtemp);
			any_driver_fault = any_driver_fault
				| (driver_present[i] & (driver_fault_byte(driver_snap[i]) != 8'h00));
			any_cooler_fault = any_cooler_fault
				| (cooler_present[i] & (cooler_fault_byte(cooler_snap[i]) != 8'h00));
		end
	end

	always_comb begin
		next_byte_one = 8'h00;
		next_byte_one[1:0] = sys_state.op_mode;
		next_byte_one[usw_pkg::SYS_FAIL_BIT] = sys_state.failure;
		next_byte_one[usw_pkg::SYS_LASER_BIT] = any_laser;
		next_byte_one[usw_pkg::SYS_ILOCK_BIT] = sys_state.interlock_open;
		next_byte_one[usw_pkg::SYS_REMOTE_BIT] = ctrl[usw_pkg::CTRL_REMOTE_BIT];
		next_byte_one[usw_pkg::SYS_OVERTEMP_BIT] = any_overtemp;
		next_byte_one[usw_pkg::SYS_FIRST_BIT] = first_pending;
	end

	always_comb begin
		next_byte_two = 8'h00;
		next_byte_two[usw_pkg::CARD_NEW_BIT] = card_new;
		next_byte_two[usw_pkg::CARD_IN_BIT] = sys_state.card_inserted;
		next_byte_two[usw_pkg::CARD_FAULT_BIT] = sys_state.card_fault;
		next_byte_two[usw_pkg::ANY_FAULT_BIT] = sys_state.failure | any_driver_fault
			| any_cooler_fault;
		next_byte_two[usw_pkg::DRIVER_FAULT_BIT] = any_driver_fault;
		next_byte_two[usw_pkg::COOLER_FAULT_BIT] = any_cooler_fault;
		next_byte_two[usw_pkg::MEAS_BIT] = sys_state.meas_connected;
		next_byte_two[usw_pkg::STATION_BIT] = sys_state.station_connected;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sys_msg <= '0;
		end else if (ce) begin
			sys_msg.byte_one <= next_byte_one;
			sys_msg.byte_two <= next_byte_two;
			sys_msg.driver_loss <= driver_lost;
			sys_msg.cooler_loss <= cooler_lost;
			sys_msg.version <= version_set;
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	always_comb begin
		next_rdata = 8'h00;
		if (reg_addr == usw_pkg::SYS_BYTE_ONE) begin
			next_rdata = sys_msg.byte_one;
		end else if (reg_addr == usw_pkg::SYS_BYTE_TWO) begin
			next_rdata = sys_msg.byte_two;
		end else if (reg_addr == usw_pkg::SYS_DRIVER_LOSS) begin
			next_rdata = sys_msg.driver_loss;
		end else if (reg_addr == usw_pkg::SYS_COOLER_LOSS) begin
			next_rdata = sys_msg.cooler_loss;
		end else if (reg_addr == usw_pkg::SYS_VERSION) begin
			next_rdata = sys_msg.version;
		end else if (reg_addr == usw_pkg::CTRL) begin
			next_rdata = ctrl;
		end else if (reg_addr == usw_pkg::VERSION_SET) begin
			next_rdata = version_set;
		end else if (reg_addr == usw_pkg::DRIVER_PRESENT) begin
			next_rdata = driver_present;
		end else if (reg_addr == usw_pkg::COOLER_PRESENT) begin
			next_rdata = cooler_present;
		end else if (reg_addr[7:6] == usw_pkg::DRIVER_WINDOW) begin
			next_rdata = driver_byte(driver_snap[reg_addr[5:3]], reg_addr[2:0]);
		end else if (reg_addr[7:6] == usw_pkg::COOLER_WINDOW) begin
			next_rdata = cooler_byte(cooler_snap[reg_addr[5:3]], reg_addr[2:0]);
		end
	end

	// Data stands only in the cycle after the read strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (ce) begin
			reg_rdata <= reg_rd ? next_rdata : 8'h00;
		end
	end

endmodule

// ==== tb/usw_encoder_sva.sv ====
// Port checker for the unit status word encoder
`timescale 1ns/1ps

module usw_encoder_sva #(
	parameter int LOSS_CYCLES = usw_pkg::LOSS_CYCLES
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Events and summaries
	input wire logic sys_msg_sent,
	input wire logic [usw_pkg::UNITS-1:0] driver_valid,
	input wire usw_pkg::usw_sys_msg_s sys_msg
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// ****************************************
	// Helpers
	// ****************************************
	int gap;
	logic pad_slot;
	assign pad_slot = (reg_addr[7:6] != 2'h0 && reg_addr[2:1] == 2'h3)
		|| (reg_addr[7:6] == 2'h2 && reg_addr[2:0] == 3'h2) || reg_addr[7:6] == 2'h3;
	// Cycles since the last message of driver unit 0
	always_ff @(posedge clk) begin
		if (rst || (ce && driver_valid[0]))
			gap <= 0;
		else if (ce && gap < LOSS_CYCLES + 8)
			gap <= gap + 1;
	end
	sequence s_ctrl_wr;
		ce && reg_wr && reg_addr == usw_pkg::CTRL;
	endsequence
	sequence s_sent;
		ce && sys_msg_sent ##1 ce;
	endsequence
	sequence s_unit_msg;
		ce && driver_valid != 8'h00 ##1 ce;
	endsequence

	// ****************************************
	// Assertions
	// ****************************************
	a_rdata_idle: assert property ($past(ce) && !$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_pad_zero: assert property ($past(ce) && $past(reg_rd) && $past(pad_slot) |-> reg_rdata == 8'h00)
		else $error("undefined byte not zero");
	a_type_onehot: assert property ($past(ce) && $past(reg_rd) && $past(reg_addr[7:6]) == 2'h1
		&& $past(reg_addr[2:0]) == 3'h2 |-> $onehot(reg_rdata[7:4]))
		else $error("type flags not one-hot");
	a_any_fault: assert property (sys_msg.byte_two[4] || sys_msg.byte_two[5]
		|| sys_msg.byte_one[2] |-> sys_msg.byte_two[3])
		else $error("summary fault bit missing");
	a_drv_loss_fault: assert property (sys_msg.driver_loss != 8'h00 |-> ##[0:2] sys_msg.byte_two[4])
		else $error("driver loss without driver fault");
	a_cool_loss_fault: assert property (sys_msg.cooler_loss != 8'h00 |-> ##[0:2] sys_msg.byte_two[5])
		else $error("cooler loss without cooler fault");
	a_loss_clear: assert property (s_unit_msg |=> (sys_msg.driver_loss & $past(driver_valid, 2)) == 8'h00)
		else $error("loss bit kept after message");
	a_loss_early: assert property ($rose(sys_msg.driver_loss[0]) |-> gap >= LOSS_CYCLES + 2)
		else $error("loss bit set too early");
	a_first_after: assert property ($fell(rst) |=> sys_msg.byte_one[7]
		&& sys_msg.version == usw_pkg::VERSION_RESET)
		else $error("first message flag or version wrong after reset");
	a_first_clear: assert property (s_sent |=> !sys_msg.byte_one[7])
		else $error("first message flag not cleared");
	a_remote_bit: assert property (s_ctrl_wr ##1 ce |=> sys_msg.byte_one[5] == $past(reg_wdata[0], 2))
		else $error("remote bit does not follow control");
endmodule

bind usw_encoder usw_encoder_sva #(.LOSS_CYCLES(LOSS_CYCLES)) usw_encoder_sva_i (.clk(clk),
	.rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sys_msg_sent(sys_msg_sent),
	.driver_valid(driver_valid), .sys_msg(sys_msg));

// ==== tb/usw_host_model.sv ====
// Register host issuing one-cycle read and write strobes
`timescale 1ns/1ps

module usw_host_model (
	// Clock
	input wire logic clk,
	// Register port
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Released lines show the inverse, never the old value
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask
endmodule

// ==== tb/tb_usw_encoder.sv ====
// Self-checking bench of the unit status word encoder
`timescale 1ns/1ps

module tb_usw_encoder;
	localparam int LOSS = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
	logic reg_wr, reg_rd;
	logic card_changed = 1'b0;
	logic sys_msg_sent = 1'b0;
	logic [7:0] driver_valid = 8'h00;
	logic [7:0] cooler_valid = 8'h00;
	usw_pkg::usw_system_s sys = '0;
	usw_pkg::usw_system_s ts;
	usw_pkg::usw_driver_s drv [8];
	usw_pkg::usw_driver_s td;
	usw_pkg::usw_cooler_s cool [8];
	usw_pkg::usw_sys_msg_s sys_msg;
	logic [7:0] dmask = 8'hFF;
	logic [7:0] cmask = 8'hFF;
	logic [7:0] ver = usw_pkg::VERSION_RESET;
	logic remote = 1'b0;
	logic [63:0] r;
	int seed = 32'h6903;
	int k;
	int miscompares = 0;
	int num_checks = 0;

	always #20 clk = ~clk;

	usw_encoder #(.LOSS_CYCLES(LOSS)) usw_encoder_i (.clk(clk), .rst(rst), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sys_state(sys), .card_changed(card_changed),
		.sys_msg_sent(sys_msg_sent), .driver_valid(driver_valid), .driver_msg(drv),
		.cooler_valid(cooler_valid), .cooler_msg(cool), .sys_msg(sys_msg));
	usw_host_model usw_host_model_i (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	// ****************************************
	// Checking and expectations
	// ****************************************
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		usw_host_model_i.write_reg(a, d);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		usw_host_model_i.read_reg(a, d);
	endtask
	task automatic wait_msg(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	function automatic logic [7:0] dbyte(input usw_pkg::usw_driver_s m, input int s);
		logic f;
		f = m.failure | m.relay_defect | m.amp_defect | m.pulse_interlock | m.overtemp;
		case (s)
			0: return {m.laser_on, m.active, m.configured, m.interlock_open, m.first_msg, m.op_mode};
			1: return {3'h0, m.overtemp, m.pulse_interlock, m.amp_defect, m.relay_defect, f};
			2: return {4'h1 << m.unit_type, m.group};
			3: return m.internal_a;
			4: return m.internal_b;
			5: return m.version;
			default: return 8'h00;
		endcase
	endfunction
	function automatic logic [7:0] cbyte(input usw_pkg::usw_cooler_s m, input int s);
		logic f;
		f = m.failure | m.peltier_defect | m.fan_defect | m.laser_overtemp | m.board_overtemp;
		case (s)
			0: return {1'b0, m.active, m.configured, m.fan_ctrl, m.first_msg, m.op_mode};
			1: return {2'h0, m.board_overtemp, m.laser_overtemp, m.fan_defect, 1'b0, m.peltier_defect, f};
			3: return m.internal_a;
			4: return m.internal_b;
			5: return m.version;
			default: return 8'h00;
		endcase
	endfunction
	// System bytes with no unit lost and no new card pending
	function automatic logic [7:0] sbyte(input int s);
		logic l, o, df, cf;
		l = 1'b0;
		o = sys.board_overtemp;
		df = 1'b0;
		cf = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (dmask[i]) begin
				l |= drv[i].laser_on;
				o |= drv[i].overtemp;
				df |= dbyte(drv[i], 1) != 8'h00;
			end
			if (cmask[i]) begin
				o |= cool[i].board_overtemp;
				cf |= cbyte(cool[i], 1) != 8'h00;
			end
		end
		case (s)
			0: return {1'b0, o, remote, sys.interlock_open, l, sys.failure, 2'h0};
			1: return {sys.station_connected, sys.meas_connected, cf, df, sys.failure | df | cf,
				sys.card_fault, sys.card_inserted, 1'b0};
			4: return ver;
			default: return 8'h00;
		endcase
	endfunction

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		for (int i = 0; i < 8; i++) begin
			drv[i] = '0;
			cool[i] = '0;
		end
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		wait_msg(2);
		check("first flag", sys_msg.byte_one & 8'h80, 8'h80);
		rd(usw_pkg::CTRL, rv);
		check("ctrl", rv, usw_pkg::CTRL_RESET);
		rd(usw_pkg::DRIVER_PRESENT, rv);
		check("present", rv, usw_pkg::PRESENT_RESET);
		rd(usw_pkg::SYS_VERSION, rv);
		check("version", rv, usw_pkg::VERSION_RESET);
		@(posedge clk);
		sys_msg_sent <= 1'b1;
		@(posedge clk);
		sys_msg_sent <= 1'b0;
		wait_msg(3);
		check("first flag", sys_msg.byte_one & 8'h80, 8'h00);
		$display("test reset done");
		for (int n = 0; n < 24; n++) begin
			r = {$random(seed), $random(seed)};
			ts = r[8:0];
			ts.failure |= ts.card_fault;
			remote = r[9];
			dmask = n < 12 ? 8'hFF : r[23:16];
			cmask = n < 12 ? 8'hFF : r[31:24];
			wr(usw_pkg::CTRL, {7'h00, remote});
			wr(usw_pkg::DRIVER_PRESENT, dmask);
			wr(usw_pkg::COOLER_PRESENT, cmask);
			@(posedge clk);
			sys <= ts;
			for (int i = 0; i < 8; i++) begin
				r = {$random(seed), $random(seed)};
				td = r[42:0];
				td.interlock_open = ts.interlock_open;
				td.group = {2'h0, r[50:49] == 2'h3 ? 2'h0 : r[50:49]};
				drv[i] <= td;
				cool[i] <= r[63:28];
			end
			driver_valid <= 8'hFF;
			cooler_valid <= 8'hFF;
			@(posedge clk);
			driver_valid <= 8'h00;
			cooler_valid <= 8'h00;
			wait_msg(2);
			check("sys one", sys_msg.byte_one & 8'hFC, sbyte(0));
			check("sys two", sys_msg.byte_two, sbyte(1));
			for (int s = 1; s < 5; s++) begin
				rd(8'(s), rv);
				check("sys reg", rv, sbyte(s));
			end
			k = n % 8;
			for (int s = 0; s < 8; s++) begin
				rd(8'(8'h40 + 8 * k + s), rv);
				check("driver reg", rv, dbyte(drv[k], s));
				rd(8'(8'h80 + 8 * k + s), rv);
				check("cooler reg", rv, cbyte(cool[k], s));
			end
		end
		$display("test random status done");
		wr(usw_pkg::DRIVER_PRESENT, 8'hFF);
		wr(usw_pkg::COOLER_PRESENT, 8'hFF);
		@(posedge clk);
		driver_valid <= 8'hFF;
		cooler_valid <= 8'hFF;
		@(posedge clk);
		driver_valid <= 8'h00;
		cooler_valid <= 8'h00;
		wait_msg(LOSS + 1);
		check("loss early", sys_msg.driver_loss | sys_msg.cooler_loss, 8'h00);
		wait_msg(1);
		check("driver loss", sys_msg.driver_loss, 8'hFF);
		check("cooler loss", sys_msg.cooler_loss, 8'hFF);
		check("loss faults", sys_msg.byte_two & 8'h38, 8'h38);
		@(posedge clk);
		driver_valid <= 8'h01;
		@(posedge clk);
		driver_valid <= 8'h00;
		wr(usw_pkg::COOLER_PRESENT, 8'h0F);
		wait_msg(3);
		check("driver loss", sys_msg.driver_loss, 8'hFE);
		check("cooler loss", sys_msg.cooler_loss, 8'h0F);
		$display("test loss done");
		@(posedge clk);
		card_changed <= 1'b1;
		@(posedge clk);
		card_changed <= 1'b0;
		wait_msg(3);
		check("new card", sys_msg.byte_two & 8'h01, 8'h01);
		wr(usw_pkg::EVENT_CLEAR, 8'h01);
		wait_msg(3);
		check("new card", sys_msg.byte_two & 8'h01, 8'h00);
		// Card change in the clearing cycle must win
		fork
			wr(usw_pkg::EVENT_CLEAR, 8'h01);
			begin
				@(posedge clk);
				card_changed <= 1'b1;
				@(posedge clk);
				card_changed <= 1'b0;
			end
		join
		wait_msg(3);
		check("new card", sys_msg.byte_two & 8'h01, 8'h01);
		ver = 8'h99;
		wr(usw_pkg::VERSION_SET, ver);
		wr(usw_pkg::SYS_VERSION, 8'h00);
		wait_msg(3);
		check("version", sys_msg.version, ver);
		rd(usw_pkg::SYS_VERSION, rv);
		check("version", rv, ver);
		rd(8'hC5, rv);
		check("unmapped", rv, 8'h00);
		$display("test events done");
		ce <= 1'b0;
		wr(usw_pkg::CTRL, {7'h00, !remote});
		ce <= 1'b1;
		rd(usw_pkg::CTRL, rv);
		check("frozen ctrl", rv, {7'h00, remote});
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		wait_msg(2);
		check("first flag", sys_msg.byte_one & 8'h80, 8'h80);
		check("version", sys_msg.version, usw_pkg::VERSION_RESET);
		$display("test freeze and reset done");
		close_out();
	end

	// Run needs about 1300 cycles; allow fifteen times that
	initial begin
		#(40 * 20000);
		miscompares++;
		close_out();
	end
endmodule
